// >>> pkg/hpi_defines.svh
// hpi_defines.svh: address map, reset values, event count and ready delay of the host port
// assumes: included by bare name from package and design files
`ifndef HPI_DEFINES_SVH
`define HPI_DEFINES_SVH
`define HPI_ADDR_CTRL     8'h00
`define HPI_ADDR_IRQ_EN   8'h01
`define HPI_ADDR_IRQ_SRC  8'h02
`define HPI_ADDR_STATUS   8'h03
`define HPI_ADDR_SCRATCH  8'h04
`define HPI_CTRL_RST      8'h00
`define HPI_IRQ_EN_RST    8'h00
`define HPI_SCRATCH_RST   8'h00
`define HPI_NUM_EVENTS    8
`define HPI_RDY_CYCLES    2'h2
`endif

// >>> pkg/hpi_pkg.sv
// hpi_pkg.sv: types of the host port
// assumes: hpi_defines.svh is on the include path
package hpi_pkg;
  `include "hpi_defines.svh"
  typedef logic [7:0] hpi_byte_t;
  typedef enum logic [3:0]
  {
    HPI_IDLE   = 4'b0001,
    HPI_ACCESS = 4'b0010,
    HPI_DONE   = 4'b0100,
    HPI_WAIT   = 4'b1000
  } hpi_state_e;
endpackage

// >>> pkg/hpi_sync_if.sv
// hpi_sync_if.sv: carries raw and synchronised host pins between modules
// assumes: one clock, synchroniser drives the sync side
`timescale 1ns/1ps
interface hpi_sync_if;
  logic [11:0] raw;
  logic [11:0] clean;
  modport src (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// >>> hw/hpi_sync.sv
// hpi_sync.sv: three-stage synchroniser, change accepted when stages two and three agree
// assumes: clk_in domain, reset already synchronised
`timescale 1ns/1ps
module hpi_sync
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // pins
  hpi_sync_if.sync  pins
);
  logic [11:0] s1_r, s2_r, s3_r, clean_r;
  logic [11:0] clean_nxt;

  // accept a bit only once two late stages agree
  always_comb
  begin
    clean_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & clean_r);
  end

  // stages reset to the idle (high) level of the strobes
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s1_r    <= 12'hfff;
      s2_r    <= 12'hfff;
      s3_r    <= 12'hfff;
      clean_r <= 12'hfff;
    end
    else
    begin
      s1_r    <= pins.raw;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      clean_r <= clean_nxt;
    end
  end

  assign pins.clean = clean_r;
endmodule

// >>> hw/hpi_top.sv
// hpi_top.sv: parallel host port with byte bus, ready handshake, interrupt and reset
// assumes: asynchronous host strobes; address and write data stable while strobe is low
`timescale 1ns/1ps
`include "hpi_defines.svh"
// Contract
// (R1) write stores host byte into addressed register
// (R2) read drives register onto bus, else released
// (R3) attention low only for enabled pending events
// (R4) attention stays low until serviced
// (R5) reading source clears flags, attention recomputed
// (R6) host reads source after attention
// (R7) reset returns command registers to defaults
// (R8) reset held high; undriven counts high
// (R9) select low required for any transfer
// (R10) store strobe writes byte to selected register
// (R11) fetch strobe returns selected register
// (R12) done handshake low marks access complete
// (R13) attention is inverted OR of gated flags
// (R14) reset clears pending flags
module hpi_top
  import hpi_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // host strobes and address
  input  wire logic       select_n_in,
  input  wire logic       store_n_in,
  input  wire logic       fetch_n_in,
  input  wire logic [7:0] register_selector_in,
  // host byte bus, split three ways
  input  wire logic [7:0] host_byte_bus_in,
  output logic      [7:0] host_byte_bus_out,
  output logic            host_byte_bus_oe_out,
  // handshake and attention
  output logic            done_n_out,
  output logic            attention_n_out,
  // block side: events in, control out
  input  wire logic [7:0] event_in,
  input  wire logic [7:0] status_in,
  output logic      [7:0] control_out
);
  logic       rst_s1_r, rst_s2_r, rstn;
  hpi_sync_if pins_if ();
  logic       sel_n, st_n, fe_n;

  hpi_state_e state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  hpi_byte_t  ctrl_r, ctrl_nxt, en_r, en_nxt, scr_r, scr_nxt;
  hpi_byte_t  pend_r, pend_nxt, rdata_r, rdata_nxt;
  logic       oe_r, oe_nxt, done_r, done_nxt, attn_r, attn_nxt;
  logic       is_read;

  // reset release through two flops; undriven pin is pulled high outside (R8)
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rstn = rst_s2_r;

  // strobes pass the synchroniser; address and data are sampled once strobes settle
  assign pins_if.raw = {9'h1ff, select_n_in, store_n_in, fetch_n_in};
  assign sel_n = pins_if.clean[2];
  assign st_n  = pins_if.clean[1];
  assign fe_n  = pins_if.clean[0];

  hpi_sync u_sync
  (
    .clk_in  (clk_in),
    .rstn_in (rstn),
    .pins    (pins_if.sync)
  );

  // access sequencer, registers and pending flags
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ctrl_nxt  = ctrl_r;
    en_nxt    = en_r;
    scr_nxt   = scr_r;
    rdata_nxt = rdata_r;
    oe_nxt    = oe_r;
    done_nxt  = done_r;
    is_read   = 1'b0;
    pend_nxt  = pend_r;
    case (state_r)
      HPI_IDLE:
      begin
        if (!sel_n && (!st_n || !fe_n)) // R9
        begin
          state_nxt = HPI_ACCESS;
          cnt_nxt   = `HPI_RDY_CYCLES;
        end
      end
      HPI_ACCESS:
      begin
        if (sel_n || (st_n && fe_n))
          state_nxt = HPI_IDLE;
        else if (cnt_r != 2'h0)
          cnt_nxt = cnt_r - 2'h1;
        else if (!st_n)
        begin
          case (register_selector_in) // R1 R10
            `HPI_ADDR_CTRL:    ctrl_nxt = host_byte_bus_in;
            `HPI_ADDR_IRQ_EN:  en_nxt   = host_byte_bus_in;
            `HPI_ADDR_SCRATCH: scr_nxt  = host_byte_bus_in;
            default:           ctrl_nxt = ctrl_r;
          endcase
          done_nxt  = 1'b1; // R12
          state_nxt = HPI_DONE;
        end
        else
        begin
          is_read = 1'b1;
          case (register_selector_in) // R11
            `HPI_ADDR_CTRL:    rdata_nxt = ctrl_r;
            `HPI_ADDR_IRQ_EN:  rdata_nxt = en_r;
            `HPI_ADDR_IRQ_SRC: rdata_nxt = pend_r; // R6
            `HPI_ADDR_STATUS:  rdata_nxt = status_in;
            `HPI_ADDR_SCRATCH: rdata_nxt = scr_r;
            default:           rdata_nxt = 8'h00;
          endcase
          oe_nxt    = 1'b1; // R2
          done_nxt  = 1'b1; // R12
          state_nxt = HPI_DONE;
        end
      end
      HPI_DONE:
      begin
        if (sel_n || (st_n && fe_n))
        begin
          oe_nxt    = 1'b0; // R2
          done_nxt  = 1'b0;
          state_nxt = HPI_WAIT;
        end
      end
      HPI_WAIT:
      begin
        state_nxt = HPI_IDLE;
      end
      default:
      begin
        state_nxt = HPI_IDLE;
        oe_nxt    = 1'b0;
        done_nxt  = 1'b0;
      end
    endcase
    // read of source clears the flags it showed; a new event wins over the clear
    if (is_read && register_selector_in == `HPI_ADDR_IRQ_SRC)
      pend_nxt = pend_r & ~pend_r; // R5
    pend_nxt = pend_nxt | event_in; // R4
    attn_nxt = |(pend_nxt & en_nxt); // R3 R13
  end

  // state registers; reset returns defaults and clears pending flags
  always_ff @(posedge clk_in or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= HPI_IDLE;
      cnt_r   <= 2'h0;
      ctrl_r  <= `HPI_CTRL_RST; // R7
      en_r    <= `HPI_IRQ_EN_RST; // R7
      scr_r   <= `HPI_SCRATCH_RST;
      pend_r  <= 8'h00; // R14
      rdata_r <= 8'h00;
      oe_r    <= 1'b0;
      done_r  <= 1'b0;
      attn_r  <= 1'b0; // R14
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ctrl_r  <= ctrl_nxt;
      en_r    <= en_nxt;
      scr_r   <= scr_nxt;
      pend_r  <= pend_nxt;
      rdata_r <= rdata_nxt;
      oe_r    <= oe_nxt;
      done_r  <= done_nxt;
      attn_r  <= attn_nxt;
    end
  end

  // pin outputs, active low where the pins are
  assign host_byte_bus_out    = rdata_r;
  assign host_byte_bus_oe_out = oe_r;
  assign done_n_out           = ~done_r;
  assign attention_n_out      = ~attn_r;
  assign control_out          = ctrl_r;
endmodule

// >>> verification/hpi_checker.sv
// hpi_checker.sv: port assertions of the host port
// assumes: bound to hpi_top, one clock domain
`timescale 1ns/1ps
module hpi_checker
(
  // clock, reset and strobes
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       select_n_in,
  input wire logic       store_n_in,
  input wire logic       fetch_n_in,
  // events and answers
  input wire logic [7:0] event_in,
  input wire logic [7:0] control_out,
  input wire logic       host_byte_bus_oe_out,
  input wire logic       done_n_out,
  input wire logic       attention_n_out
);
  logic ev_r;
  logic ev_nxt;
  // remembers that an event arrived since reset
  always_comb ev_nxt = ev_r | (event_in != 8'h00);
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ev_r <= 1'b0;
    else
      ev_r <= ev_nxt;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_read_drives: assert property (
    $rose(host_byte_bus_oe_out) |-> !fetch_n_in && !select_n_in) else $error("drive off read");
  a_write_quiet: assert property (
    $fell(done_n_out) && !store_n_in |-> !host_byte_bus_oe_out) else $error("drive on write");
  a_answer_bound: assert property (
    $fell(store_n_in && fetch_n_in) && !select_n_in |-> ##[4:12] !done_n_out)
    else $error("no done");
  a_done_release: assert property (
    !done_n_out && $rose(store_n_in && fetch_n_in) |-> ##[1:8] done_n_out)
    else $error("done held");
  a_ctrl_by_write: assert property (
    $changed(control_out) |-> !select_n_in) else $error("control moved");
  a_att_release: assert property (
    $rose(attention_n_out) |-> !select_n_in) else $error("attention dropped");
  a_att_cause: assert property (
    !attention_n_out |-> ev_r) else $error("attention uncaused");
  a_reset_quiet: assert property (
    $rose(rstn_in) |-> attention_n_out && done_n_out && control_out == 8'h00)
    else $error("reset state");
endmodule
bind hpi_top hpi_checker chk (.clk_in, .rstn_in, .select_n_in, .store_n_in, .fetch_n_in,
  .event_in, .control_out, .host_byte_bus_oe_out, .done_n_out, .attention_n_out);

// >>> verification/hpi_host.sv
// hpi_host.sv: host processor model for the parallel port
// assumes: shares the port clock; resolves the byte bus
`timescale 1ns/1ps
module hpi_host
  import hpi_pkg::*;
(
  // clock and device answers
  input  wire logic      clk_in,
  input  wire hpi_byte_t dat_in,
  input  wire logic      oe_in,
  input  wire logic      done_n_in,
  // strobes, address and bus
  output logic           sel_n_out = 1'b1,
  output logic           wr_n_out = 1'b1,
  output logic           rd_n_out = 1'b1,
  output hpi_byte_t      adr_out = 8'h00,
  output hpi_byte_t      bus_out
);
  logic      drive_r = 1'b0;
  hpi_byte_t wdata_r = 8'h00;
  hpi_byte_t junk_r = 8'h55;
  // a released bus changes every cycle so stale data never matches
  always_ff @(posedge clk_in)
    junk_r <= ~junk_r;
  assign bus_out = drive_r ? wdata_r : (oe_in ? dat_in : junk_r);
  // one whole access; ok low if a handshake never came
  task automatic access(input logic wr, input hpi_byte_t a, d,
                        output hpi_byte_t q, output logic ok);
    int n;
    n = 0;
    repeat (4) @(posedge clk_in);
    #1 adr_out = a;
    wdata_r = d;
    drive_r = wr;
    sel_n_out = 1'b0;
    wr_n_out = !wr;
    rd_n_out = wr;
    while (done_n_in !== 1'b0 && n < 40) @(posedge clk_in) #1 n++;
    ok = done_n_in === 1'b0;
    q = bus_out;
    @(posedge clk_in) #1 wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    drive_r = 1'b0;
    n = 0;
    while (done_n_in !== 1'b1 && n < 40) @(posedge clk_in) #1 n++;
    ok = ok && done_n_in === 1'b1;
    repeat (4) @(posedge clk_in);
    #1 sel_n_out = 1'b1;
  endtask
endmodule

// >>> verification/hpi_top_test.sv
// hpi_top_test.sv: self-checking bench of the host port
// assumes: host model runs the bus; bench drives events, status, reset
`timescale 1ns/1ps
`include "hpi_defines.svh"
module hpi_top_test
  import hpi_pkg::*;
  ;
  logic      clk_in = 1'b0;
  logic      rstn_in = 1'b0;
  logic      select_n_in, store_n_in, fetch_n_in, done_n_out, attention_n_out, ok;
  logic      host_byte_bus_oe_out;
  hpi_byte_t register_selector_in, host_byte_bus_in, host_byte_bus_out, control_out, q;
  hpi_byte_t event_in = 8'h00;
  hpi_byte_t status_in = 8'h5a;
  int        num_errors = 0;
  int        checks = 0;
  // port under test and the host facing it
  hpi_top DUT (.clk_in, .rstn_in, .select_n_in, .store_n_in, .fetch_n_in, .register_selector_in,
    .host_byte_bus_in, .host_byte_bus_out, .host_byte_bus_oe_out, .done_n_out,
    .attention_n_out, .event_in, .status_in, .control_out);
  hpi_host host (.clk_in, .dat_in(host_byte_bus_out), .oe_in(host_byte_bus_oe_out),
    .done_n_in(done_n_out), .sel_n_out(select_n_in), .wr_n_out(store_n_in),
    .rd_n_out(fetch_n_in), .adr_out(register_selector_in), .bus_out(host_byte_bus_in));
  initial
    forever #2.5 clk_in = ~clk_in;
  task automatic cmp(input hpi_byte_t got, exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, exp);
    cmp({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input hpi_byte_t a, d);
    host.access(1'b1, a, d, q, ok);
    cmp_bit(ok, 1'b1);
  endtask
  task automatic rd(input hpi_byte_t a, exp);
    host.access(1'b0, a, 8'h00, q, ok);
    cmp_bit(ok, 1'b1);
    cmp(q, exp);
  endtask
  // one-cycle event pulse, then time to settle
  task automatic pulse(input hpi_byte_t e);
    event_in = e;
    wait_c(1);
    event_in = 8'h00;
    wait_c(4);
  endtask
  task automatic t_regs;
    wr(`HPI_ADDR_CTRL, 8'ha5);
    cmp(control_out, 8'ha5);
    rd(`HPI_ADDR_CTRL, 8'ha5);
    wr(`HPI_ADDR_SCRATCH, 8'h3c);
    rd(`HPI_ADDR_SCRATCH, 8'h3c);
    wr(`HPI_ADDR_STATUS, 8'hff);
    rd(`HPI_ADDR_STATUS, 8'h5a);
    rd(8'h7f, 8'h00);
    cmp_bit(host_byte_bus_oe_out, 1'b0);
    $display("end regs");
  endtask
  task automatic t_irq;
    wr(`HPI_ADDR_IRQ_EN, 8'h04);
    pulse(8'h04);
    cmp_bit(attention_n_out, 1'b0);
    wait_c(20);
    cmp_bit(attention_n_out, 1'b0);
    rd(`HPI_ADDR_IRQ_SRC, 8'h04);
    cmp_bit(attention_n_out, 1'b1);
    pulse(8'h10);
    cmp_bit(attention_n_out, 1'b1);
    wr(`HPI_ADDR_IRQ_EN, 8'h14);
    cmp_bit(attention_n_out, 1'b0);
    rd(`HPI_ADDR_IRQ_SRC, 8'h10);
    cmp_bit(attention_n_out, 1'b1);
    $display("end irq");
  endtask
  // an event on the very edge that clears the source must stay pending;
  // the host strobes at edge 4 and the clearing edge is 8 edges later
  task automatic t_clash;
    fork
      rd(`HPI_ADDR_IRQ_SRC, 8'h00);
      begin
        wait_c(11);
        event_in = 8'h04;
        wait_c(1);
        event_in = 8'h00;
      end
    join
    cmp_bit(attention_n_out, 1'b0);
    rd(`HPI_ADDR_IRQ_SRC, 8'h04);
    cmp_bit(attention_n_out, 1'b1);
    $display("end clash");
  endtask
  task automatic t_reset;
    wr(`HPI_ADDR_SCRATCH, 8'hff);
    pulse(8'h04);
    rstn_in = 1'b0;
    wait_c(16);
    rstn_in = 1'b1;
    wait_c(4);
    cmp(control_out, 8'h00);
    cmp_bit(attention_n_out, 1'b1);
    rd(`HPI_ADDR_SCRATCH, 8'h00);
    rd(`HPI_ADDR_IRQ_EN, 8'h00);
    rd(`HPI_ADDR_IRQ_SRC, 8'h00);
    $display("end reset");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    wait_c(16);
    rstn_in = 1'b1;
    t_regs;
    t_irq;
    t_clash;
    t_reset;
    results;
  end
  // watchdog well past the expected run
  initial
  begin
    #50000;
    num_errors++;
    results;
  end
endmodule
